/* File: rtl/fbpe_map.vh */
// fbpe_map.vh: register offsets, field positions, reset values and timing for the flash bank controller
// assumes an AHB-Lite slave with one 32-bit word per register
`ifndef FBPE_MAP_VH
`define FBPE_MAP_VH
`define FBPE_OFF_CTRL      8'h00
`define FBPE_OFF_PROT      8'h04
`define FBPE_OFF_ADDR      8'h08
`define FBPE_OFF_STAT      8'h0C
`define FBPE_OFF_PROTLD    8'h10
`define FBPE_BIT_WOP       0
`define FBPE_BIT_WIPE      1
`define FBPE_BIT_WHOLE     2
`define FBPE_BIT_HIGH_VOLTAGE_ENABLE      3
`define FBPE_PROT_RST      8'hFF
`define FBPE_ARRAY_LO      16'h0450
`define FBPE_ARRAY_HI      16'h7FFF
`define FBPE_PROT_EXC      8'hFE
`define FBPE_PROT_EXC_ADR  16'h7F00
`define FBPE_CLK_MHZ       200
`define FBPE_DLY_NS        1000
`endif

/* File: rtl/fbpe_ctrl.v */
// fbpe_ctrl.v: program/erase control and block protection for the second flash array
// assumes an AHB-Lite master; the array itself lies outside and obeys the pump and wipe strobes
`timescale 1ns/1ps
`include "fbpe_map.vh"
module fbpe_ctrl #(
  parameter DLY_NS = `FBPE_DLY_NS
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [7:0]  nv_protect_byte,
  input  wire        nv_protect_valid,
  input  wire        arr_wr,
  input  wire [15:0] arr_addr,
  input  wire [7:0]  arr_data,
  output reg         pump_on,
  output reg         array_hv,
  output reg         erase_go,
  output reg         erase_whole,
  output reg         program_go,
  output reg  [15:0] target_addr,
  output reg  [7:0]  prog_data,
  output reg         prog_latch,
  output reg         wipe_protect_bytes
);
  // setup delay counted in hclk cycles before high voltage may be raised;
  // rounded up so a short parameter never gives less than the asked time
  localparam integer DLY_CYC  = (DLY_NS * `FBPE_CLK_MHZ + 999) / 1000;
  localparam [15:0]  DLY_LOAD = DLY_CYC[15:0];

  // sequence states, one-hot
  localparam [3:0]   S_IDLE   = 4'h1;
  localparam [3:0]   S_SEL    = 4'h2;
  localparam [3:0]   S_RD     = 4'h4;
  localparam [3:0]   S_ARMED  = 4'h8;

  // bus phase capture
  reg                ap_q;
  reg                apw_q;
  reg        [7:0]   apa_q;

  // control register bits
  reg                wop_q;
  reg                wipe_q;
  reg                whole_q;
  reg                high_voltage_enable_q;

  // protection, sequence and target state
  reg        [7:0]   prot_q;
  reg        [3:0]   seq_q;
  reg        [3:0]   seq_d;
  reg        [15:0]  tgt_q;
  reg        [15:0]  dly_q;

  // protection start for a protect byte; bit 16 set means no protection at all
  function [16:0] prot_start;
    input [7:0]  b;
    reg   [15:0] a;
    begin
      // bit 15 of the start sits above the array top, so only bits 14:7 matter
      a = {1'b0, b, 7'h00};
      if (b == `FBPE_PROT_EXC) begin
        a = `FBPE_PROT_EXC_ADR;
      end
      if (a < `FBPE_ARRAY_LO) begin
        a = `FBPE_ARRAY_LO;
      end
      prot_start = {(b == 8'hFF), a};
    end
  endfunction

  // true when the address lies between the protection start and the array top
  function is_prot;
    input [7:0]  b;
    input [15:0] adr;
    reg   [16:0] s;
    begin
      s = prot_start(b);
      is_prot = !s[16] && (adr >= s[15:0]) && (adr <= `FBPE_ARRAY_HI);
    end
  endfunction

  // data phase decode; write data is only valid one cycle after the address
  wire               wr_now    = apw_q;
  wire               rd_now    = ap_q & ~apw_q;
  wire               wr_ctrl   = wr_now & (apa_q == `FBPE_OFF_CTRL);
  wire               wr_protld = wr_now & (apa_q == `FBPE_OFF_PROTLD);
  wire               rd_prot   = rd_now & (apa_q == `FBPE_OFF_PROT);
  wire               sel_wop   = hwdata[`FBPE_BIT_WOP];
  wire               sel_wipe  = hwdata[`FBPE_BIT_WIPE];
  wire               sel_hv    = hwdata[`FBPE_BIT_HIGH_VOLTAGE_ENABLE];
  wire               any_sel_q = wop_q | wipe_q;
  wire               tgt_prot  = is_prot(prot_q, tgt_q);
  wire               arm_now   = arr_wr & any_sel_q & (seq_q == S_RD);
  wire               hv_allow  = any_sel_q & (seq_q == S_ARMED) & (dly_q == 16'h0000) & ~tgt_prot;
  wire               vec_wipe  = wr_protld & high_voltage_enable_q & wipe_q & hwdata[8];
  wire               addr_rd   = hready & hsel & htrans[1] & ~hwrite;

  // ahb address phase capture; zero wait states
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q  <= 1'b0;
      apw_q <= 1'b0;
      apa_q <= 8'h00;
    end else if (hready) begin
      ap_q  <= hsel & htrans[1];
      apw_q <= hsel & htrans[1] & hwrite;
      apa_q <= haddr[7:0];
    end
  end

  // select bits; a write asking for both selects at once leaves both unchanged
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wop_q   <= 1'b0;
      wipe_q  <= 1'b0;
      whole_q <= 1'b0;
    end else if (wr_ctrl) begin
      whole_q <= hwdata[`FBPE_BIT_WHOLE];
      if (!(sel_wop & sel_wipe)) begin
        wop_q  <= sel_wop & ~wipe_q;
        wipe_q <= sel_wipe & ~wop_q;
      end
    end
  end

  // high voltage: a clear always takes, a set only when the sequence is armed
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_voltage_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      if (!sel_hv) begin
        high_voltage_enable_q <= 1'b0;
      end else if (hv_allow) begin
        high_voltage_enable_q <= 1'b1;
      end
    end
  end

  // sequence: select, protect read, array write, then the setup wait
  always @* begin
    seq_d = seq_q;
    if (wr_ctrl && !high_voltage_enable_q) begin
      if ((sel_wop ^ sel_wipe) && !any_sel_q) begin
        seq_d = S_SEL;
      end else if (!(sel_wop | sel_wipe)) begin
        seq_d = S_IDLE;
      end
    end
    case (seq_q)
      S_IDLE: begin
      end
      S_SEL: begin
        if (rd_prot) begin
          seq_d = S_RD;
        end
      end
      S_RD: begin
        if (arm_now) begin
          seq_d = S_ARMED;
        end
      end
      S_ARMED: begin
      end
      default: begin
        seq_d = S_IDLE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_q <= S_IDLE;
    end else begin
      seq_q <= seq_d;
    end
  end

  // target capture and setup counter; only the write that arms is latched
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgt_q <= 16'h0000;
      dly_q <= 16'h0000;
    end else if (arm_now) begin
      tgt_q <= arr_addr;
      dly_q <= DLY_LOAD;
    end else if (dly_q != 16'h0000) begin
      dly_q <= dly_q - 16'h0001;
    end
  end

  // protect byte; the vector page wipe wins over a load in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prot_q <= `FBPE_PROT_RST;
    end else if (vec_wipe) begin
      prot_q <= `FBPE_PROT_RST;
    end else if (wr_protld) begin
      prot_q <= hwdata[7:0];                                         // first-array program path
    end else if (nv_protect_valid) begin
      prot_q <= nv_protect_byte;
    end
  end

  // program latch follows every array write while the write select is set
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_data  <= 8'h00;
      prog_latch <= 1'b0;
    end else begin
      prog_latch <= 1'b0;
      if (arr_wr && wop_q) begin
        prog_data  <= arr_data;
        prog_latch <= 1'b1;
      end
    end
  end

  // one-cycle notice that both protect bytes were wiped with the vector page
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wipe_protect_bytes <= 1'b0;
    end else begin
      wipe_protect_bytes <= vec_wipe;
    end
  end

  // pump and array strobes lag the control bit by one cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pump_on     <= 1'b0;
      array_hv    <= 1'b0;
      erase_go    <= 1'b0;
      erase_whole <= 1'b0;
      program_go  <= 1'b0;
    end else begin
      pump_on     <= high_voltage_enable_q;
      array_hv    <= high_voltage_enable_q;
      erase_go    <= high_voltage_enable_q & wipe_q;
      erase_whole <= whole_q;
      program_go  <= high_voltage_enable_q & wop_q;
    end
  end

  // page erase aligns the target to its 128-byte page of two rows
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      target_addr <= 16'h0000;
    end else if (whole_q) begin
      target_addr <= tgt_q;
    end else begin
      target_addr <= {tgt_q[15:7], 7'h00};
    end
  end

  // the slave never stalls and never reports an error
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read data is registered at the address edge so it stands in the data phase;
  // unmapped offsets read zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_rd) begin
      case (haddr[7:0])
        `FBPE_OFF_CTRL: begin
          hrdata <= {28'h0000000, high_voltage_enable_q, whole_q, wipe_q, wop_q};
        end
        `FBPE_OFF_PROT: begin
          hrdata <= {24'h000000, prot_q};
        end
        `FBPE_OFF_ADDR: begin
          hrdata <= {16'h0000, tgt_q};
        end
        `FBPE_OFF_STAT: begin
          hrdata <= {27'h0000000, tgt_prot, seq_q};
        end
        default: begin
          hrdata <= 32'h0000_0000;
        end
      endcase
    end
  end
endmodule // fbpe_ctrl

/* File: test/fbpe_ctrl_properties.sv */
// fbpe_ctrl_properties.sv: port-level checks of the flash bank controller
// assumes binding onto fbpe_ctrl with one clock and an active-low async reset
`timescale 1ns/1ps
module fbpe_ctrl_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hresp,
  input wire logic        hreadyout,
  input wire logic        pump_on,
  input wire logic        array_hv,
  input wire logic        erase_go,
  input wire logic        erase_whole,
  input wire logic        program_go,
  input wire logic [15:0] target_addr,
  input wire logic        prog_latch
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_latch_pulse; prog_latch ##1 !prog_latch; endsequence
  property p_pump; pump_on == array_hv; endproperty
  a_pump: assert property (p_pump) else $error("pump and array voltage differ");
  property p_excl; !(erase_go && program_go); endproperty
  a_excl: assert property (p_excl) else $error("erase and program both active");
  property p_erase_hv; erase_go |-> array_hv; endproperty
  a_erase_hv: assert property (p_erase_hv) else $error("erase without high voltage");
  property p_prog_hv; program_go |-> pump_on; endproperty
  a_prog_hv: assert property (p_prog_hv) else $error("program without pump");
  property p_page; erase_go && !erase_whole |-> target_addr[6:0] == 7'h00; endproperty
  a_page: assert property (p_page) else $error("page target not aligned");
  property p_latch; $rose(prog_latch) |-> s_latch_pulse; endproperty
  a_latch: assert property (p_latch) else $error("latch pulse too long");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_ready; hreadyout == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
endmodule // fbpe_ctrl_props
bind fbpe_ctrl fbpe_ctrl_props u_props (.hclk(hclk), .hresetn(hresetn), .hresp(hresp), .hreadyout(hreadyout),
  .pump_on(pump_on), .array_hv(array_hv), .erase_go(erase_go), .erase_whole(erase_whole),
  .program_go(program_go), .target_addr(target_addr), .prog_latch(prog_latch));

/* File: test/test_flash_bank_program_erase_ctrl.sv */
// test_flash_bank_program_erase_ctrl.sv: register-sequence tests of the flash bank controller
// assumes zero-wait AHB-Lite slave; protect byte comes from the nonvolatile load port in each run, then from the protect load register
`timescale 1ns/1ps
`include "fbpe_map.vh"
module test_flash_bank_program_erase_ctrl;
  logic        hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, nv_protect_valid = 0, arr_wr = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  nv_protect_byte = 8'hFF, arr_data = 8'h00, prog_data;
  logic [15:0] arr_addr = 0, target_addr, st;
  logic hreadyout, hresp, pump_on, array_hv, erase_go, erase_whole, program_go, prog_latch, wipe_protect_bytes;
  integer num_errors = 0, checked = 0;
  always #2.5 hclk = ~hclk;
  fbpe_ctrl #(.DLY_NS(10)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .nv_protect_byte(nv_protect_byte), .nv_protect_valid(nv_protect_valid), .arr_wr(arr_wr),
    .arr_addr(arr_addr), .arr_data(arr_data), .pump_on(pump_on), .array_hv(array_hv), .erase_go(erase_go),
    .erase_whole(erase_whole), .program_go(program_go), .target_addr(target_addr), .prog_data(prog_data),
    .prog_latch(prog_latch), .wipe_protect_bytes(wipe_protect_bytes));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    haddr <= a; hwrite <= w; htrans <= 2'h2;
    @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0; hwdata <= d;
    @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic run(input logic [7:0] pb, input logic [15:0] ad, input logic [3:0] sel);
    logic ok;
    nv_protect_valid <= 1; nv_protect_byte <= pb; @(posedge hclk); nv_protect_valid <= 0;
    st = (pb == `FBPE_PROT_EXC) ? `FBPE_PROT_EXC_ADR : {1'b0, pb, 7'h00};
    if (st < `FBPE_ARRAY_LO) st = `FBPE_ARRAY_LO;
    ok = (pb == 8'hFF) || (ad < st);
    // bench code never runs from the array and raises no interrupts
    xfer(`FBPE_OFF_CTRL, 1, sel);
    xfer(`FBPE_OFF_PROT, 0, 0); chk("protect", pb, r);
    arr_wr <= 1; arr_addr <= ad; arr_data <= ad[7:0]; @(posedge hclk); arr_wr <= 0;
    #1 chk("prog_latch", sel[0], prog_latch);
    if (sel[0]) chk("prog_data", ad[7:0], prog_data);
    repeat (8) @(posedge hclk);
    xfer(`FBPE_OFF_ADDR, 0, 0); chk("target latch", ad, r);
    xfer(`FBPE_OFF_STAT, 0, 0); chk("status", {!ok, 4'h8}, r);
    xfer(`FBPE_OFF_CTRL, 1, sel | 4'h8); repeat (2) @(posedge hclk);
    chk("pump_on", ok, pump_on);
    chk("erase_go", ok & sel[1], erase_go);
    chk("program_go", ok & sel[0], program_go);
    if (ok && sel == 4'h2) chk("target", ad & 16'hFF80, target_addr);
    if (ok) chk("whole", sel[2], erase_whole);
    xfer(`FBPE_OFF_CTRL, 1, 32'h8); xfer(`FBPE_OFF_CTRL, 1, 32'h0);
    $display("test protect %h addr %h done", pb, ad);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1; @(posedge hclk);
    xfer(`FBPE_OFF_PROT, 0, 0); chk("protect reset", 8'hFF, r);
    xfer(32'h20, 0, 0); chk("unmapped", 0, r);
    run(8'hFF, 16'h0450, 4'h2);
    run(8'hFE, 16'h7EFF, 4'h6);
    run(8'hFE, 16'h7F00, 4'h2);
    run(8'hFD, 16'h7E7F, 4'h2);
    run(8'hFD, 16'h7E80, 4'h1);
    run(8'h09, 16'h047F, 4'h1);
    run(8'h09, 16'h0480, 4'h2);
    run(8'h00, 16'h0450, 4'h6);
    run(8'h08, 16'h0450, 4'h2);
    xfer(`FBPE_OFF_PROTLD, 1, 32'h40); xfer(`FBPE_OFF_PROT, 0, 0); chk("protect load", 32'h40, r);
    xfer(`FBPE_OFF_CTRL, 1, 32'h2); xfer(`FBPE_OFF_PROT, 0, 0);
    arr_wr <= 1; arr_addr <= 16'h0450; @(posedge hclk); arr_wr <= 0;
    repeat (8) @(posedge hclk);
    xfer(`FBPE_OFF_CTRL, 1, 32'hA); xfer(`FBPE_OFF_PROTLD, 1, 32'h100);
    #1 chk("vector wipe", 1, wipe_protect_bytes);
    @(posedge hclk);
    xfer(`FBPE_OFF_PROT, 0, 0); chk("protect wiped", 32'hFF, r);
    xfer(`FBPE_OFF_CTRL, 1, 32'h8); xfer(`FBPE_OFF_CTRL, 1, 32'h0);
    $display("test vector page wipe done");
    xfer(`FBPE_OFF_CTRL, 1, 32'h3); xfer(`FBPE_OFF_CTRL, 0, 0); chk("both selects", 0, r & 32'h3);
    xfer(`FBPE_OFF_CTRL, 1, 32'h2); xfer(`FBPE_OFF_CTRL, 1, 32'hA); repeat (2) @(posedge hclk);
    chk("pump no sequence", 0, pump_on);
    $display("test interlocks done");
    final_report;
  end
endmodule // test_flash_bank_program_erase_ctrl
